// ==== core/edge_sync.v ====
// three-flop synchroniser with edge detect for one outside level
// assumes a single clock; reset synchronous active high
module edge_sync (
  input wire clk_in,
  input wire reset_in,
  input wire async_in,
  output wire level_out,
  output wire rise_out
);
  reg [2:0] stage;
  reg last;
  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      stage <= 3'h0;
      last <= 1'b0;
    end
    else
    begin
      stage <= {stage[1:0], async_in};
      // change counts only once the second and third stages agree
      if (stage[1] == stage[2])
        last <= stage[2];
    end
  end
  assign level_out = last;
  assign rise_out = (stage[1] == stage[2]) && stage[2] && !last;
endmodule // edge_sync

// ==== core/integration_timing.v ====
// integration period control: internal power-of-two or host sync timing
// assumes oscillator arrives as a pin level, bus decoder delivers pulses
`include "light_timing_map.vh"

// Function
// - bit 4 picks internal or external timing
// - internal period is 2^n oscillator cycles
// - n comes from command bits 3:2
// - first sync starts, later syncs restart
// - count oscillator cycles between syncs, readable
// - oscillator handling identical in both modes
// - external count follows interval, 65536 limit
// - oscillator 725 kHz nominal, inverse resistor
// - answer only to address 1000100
// - decode three-bit timing field, two reserved
// - address byte msb set is sync
// - data bytes refresh every conversion end
module integration_timing #(
  parameter CNT_W = `CNT_WIDTH
) (
  input wire clk_in,
  input wire reset_in,
  input wire osc_in,
  input wire write_strobe_in,
  input wire [6:0] target_addr_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] write_data_in,
  input wire [15:0] converter_count_in,
  output wire [7:0] command_out,
  output wire integrating_out,
  output wire conversion_done_out,
  output wire count_clear_out,
  output reg [7:0] data_low_out,
  output reg [7:0] data_high_out,
  output reg timer_overflow_out
);
  // ----------------------------------------------------------------
  // oscillator edges
  // ----------------------------------------------------------------
  wire osc_tick;
  // one edge detector for both modes, so period is never mode-skewed
  // only the rising edge matters here, the settled level is left open
  edge_sync osc_sync (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .async_in(osc_in),
    .level_out(),
    .rise_out(osc_tick)
  );

  // ----------------------------------------------------------------
  // command register and sync decode
  // ----------------------------------------------------------------
  reg [7:0] command;
  wire addressed = write_strobe_in && (target_addr_in == `TARGET_ADDR);
  wire sync_write = addressed && reg_addr_in[`SYNC_ADDR_BIT];
  wire cmd_write = addressed && !reg_addr_in[`SYNC_ADDR_BIT] && (reg_addr_in == `CMD_ADDR);
  wire external = command[`TIMING_SOURCE_BIT];
  wire [2:0] timing_field = command[`TIMING_SOURCE_BIT:`RES_LOW_BIT];
  wire reserved = external && command[`RES_HIGH_BIT];
  wire timer_select = (timing_field == `TIMING_EXT_TIMER);
  always @(posedge clk_in)
  begin
    if (reset_in)
      command <= 8'h00;
    else if (cmd_write)
      command <= write_data_in;
  end
  assign command_out = command;

  // ----------------------------------------------------------------
  // period length for internal timing
  // ----------------------------------------------------------------
  reg [CNT_W-1:0] period;
  always @*
  begin
    case (timing_field)
      `TIMING_INT16: period = 17'h10000;
      `TIMING_INT12: period = 17'h01000;
      `TIMING_INT8: period = 17'h00100;
      `TIMING_INT4: period = 17'h00010;
      default: period = 17'h10000;
    endcase
  end

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_INT = 3'h2;
  localparam [2:0] ST_EXT = 3'h4;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [CNT_W-1:0] cycles;
  reg done;
  reg clear;
  // at or past the limit: a shorter resolution written mid-period cannot lock up
  wire int_end = osc_tick && (cycles + 17'h00001 >= period);
  always @*
  begin
    next_state = state;
    done = 1'b0;
    clear = 1'b0;
    case (state)
      ST_IDLE:
      begin
        if (reserved)
          next_state = ST_IDLE;
        else if (!external)
        begin
          next_state = ST_INT;
          clear = 1'b1;
        end
        else if (sync_write)
        begin
          next_state = ST_EXT;
          clear = 1'b1;
        end
      end
      ST_INT:
      begin
        if (reserved)
          next_state = ST_IDLE;
        else if (external && sync_write)
        begin
          // a sync right after the mode switch still starts a period
          next_state = ST_EXT;
          clear = 1'b1;
        end
        else if (external)
          next_state = ST_IDLE;
        else if (int_end)
        begin
          done = 1'b1;
          clear = 1'b1;
        end
      end
      ST_EXT:
      begin
        if (!external || reserved)
          next_state = ST_IDLE;
        else if (sync_write)
        begin
          done = 1'b1;
          clear = 1'b1;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end
  always @(posedge clk_in)
  begin
    if (reset_in)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // ----------------------------------------------------------------
  // cycle counter, 17 bits so 65536 is representable
  // ----------------------------------------------------------------
  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      cycles <= {CNT_W{1'b0}};
      timer_overflow_out <= 1'b0;
    end
    else if (clear)
    begin
      cycles <= {CNT_W{1'b0}};
      // flag reports the interval just captured, so an overflow is never lost
      if (done)
        timer_overflow_out <= (cycles == `EXT_COUNT_LIMIT);
    end
    else if (osc_tick && state != ST_IDLE)
    begin
      // saturate: a too-long interval holds at the limit, flagged, and reads back as 0000 in the 16-bit data bytes
      if (cycles == `EXT_COUNT_LIMIT)
        timer_overflow_out <= 1'b1;
      else
        cycles <= cycles + 17'h00001;
    end
  end

  // ----------------------------------------------------------------
  // data registers
  // ----------------------------------------------------------------
  wire [15:0] timer_word = cycles[15:0];
  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      data_low_out <= 8'h00;
      data_high_out <= 8'h00;
    end
    else if (done && !reserved)
    begin
      // sampled before clear restarts both counters
      if (timer_select)
      begin
        data_low_out <= timer_word[7:0];
        data_high_out <= timer_word[15:8];
      end
      else
      begin
        data_low_out <= converter_count_in[7:0];
        data_high_out <= converter_count_in[15:8];
      end
    end
  end

  assign integrating_out = (state != ST_IDLE);
  assign conversion_done_out = done;
  assign count_clear_out = clear;
endmodule // integration_timing

// ==== core/light_timing_map.vh ====
// constants for the integration timing block of the light sensor
// assumes inclusion by core design files only
`ifndef LIGHT_TIMING_MAP_VH
`define LIGHT_TIMING_MAP_VH
`define CMD_ADDR 8'h00
`define DATA_LOW_ADDR 8'h01
`define DATA_HIGH_ADDR 8'h02
`define TIMING_SOURCE_BIT 4
`define RES_HIGH_BIT 3
`define RES_LOW_BIT 2
`define SYNC_ADDR_BIT 7
`define TIMING_INT16 3'h0
`define TIMING_INT12 3'h1
`define TIMING_INT8 3'h2
`define TIMING_INT4 3'h3
`define TIMING_EXT_ADC 3'h4
`define TIMING_EXT_TIMER 3'h5
`define TARGET_ADDR 7'h44
`define OSC_FREQ_HZ 725000
`define REF_RESISTOR_KOHM 500
`define EXT_COUNT_LIMIT 65536
`define CNT_WIDTH 17
`endif

// ==== verification/host_model.sv ====
// host model: decoded bus writes into the timing block
// assumes calls start just after a falling clock edge
module host_model (
  input wire clk_in,
  output logic write_strobe_out,
  output logic [6:0] target_addr_out,
  output logic [7:0] reg_addr_out,
  output logic [7:0] write_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {write_strobe_out, target_addr_out, reg_addr_out, write_data_out} = 24'h000000;
  // released lines flip so stale values never match
  task automatic put(input logic [6:0] t, input logic [7:0] a, input logic [7:0] d);
    {target_addr_out, reg_addr_out, write_data_out} = {t, a, d};
    write_strobe_out = 1'b1;
    @(negedge clk_in);
    write_strobe_out = 1'b0;
    {target_addr_out, reg_addr_out, write_data_out} = ~{t, a, d};
    // one idle cycle, so back-to-back calls never retoggle in one step
    @(negedge clk_in);
  endtask
endmodule // host_model

// ==== verification/tb.sv ====
// self-checking bench for the integration timing block
// assumes host_model and timing_checker compiled first
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0, reset_in = 1'b1, osc = 1'b0, ws, integ, done, clr, ovf;
  logic [6:0] ta;
  logic [7:0] ra, wd, cmd, dl, dh;
  logic [15:0] conv = 16'h0000, exp;
  logic [7:0] model_cmd = 8'h00;
  logic [15:0] expq[$];
  int fails = 0, tests_run = 0, rises = 0, k;
  always #12.5 clk_in = ~clk_in;
  initial #7 forever #100 osc = ~osc;
  always @(posedge osc) rises++;
  host_model host (.clk_in(clk_in), .write_strobe_out(ws), .target_addr_out(ta),
    .reg_addr_out(ra), .write_data_out(wd));
  integration_timing dut (.clk_in(clk_in), .reset_in(reset_in), .osc_in(osc),
    .write_strobe_in(ws), .target_addr_in(ta), .reg_addr_in(ra), .write_data_in(wd),
    .converter_count_in(conv), .command_out(cmd), .integrating_out(integ),
    .conversion_done_out(done), .count_clear_out(clr), .data_low_out(dl),
    .data_high_out(dh), .timer_overflow_out(ovf));
  task automatic conclude();
    if (fails == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] want);
    tests_run++;
    if (got !== want)
    begin
      fails++;
      $display("[FAIL] %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic wait_done(input int lim);
    int i;
    i = 0;
    while (done !== 1'b1 && i < lim)
    begin
      @(negedge clk_in);
      i++;
    end
    if (i >= lim)
    begin
      fails++;
      $display("[FAIL] %0t no period end", $time);
      conclude();
    end
    else
      @(negedge clk_in);
  endtask
  // ----------------------------------------------------------------
  // model: command from decoded writes, converter value per period end
  // ----------------------------------------------------------------
  always @(posedge clk_in)
  begin
    if (done === 1'b1 && model_cmd[4:2] != 3'h5)
      expq.push_back(conv);
    if (!reset_in && ws && ta == 7'h44 && ra == 8'h00)
      model_cmd <= wd;
  end
  always @(negedge clk_in)
  begin
    if (expq.size() > 0)
      check({dh, dl}, expq.pop_front());
    check({8'h00, cmd}, {8'h00, model_cmd});
  end
  // random low bits: any address with the top bit set must act as sync
  task automatic sync_w();
    host.put(7'h44, {1'b1, 7'($urandom)}, 8'($urandom));
    @(negedge clk_in);
  endtask
  initial
  begin
    void'($urandom(32'hF50CCE4D));
    repeat (8) @(negedge clk_in);
    reset_in = 1'b0;
    check({dh, dl}, 16'h0000);
    check({8'h00, cmd}, 16'h0000);
    conv = 16'($urandom);
    for (int c = 0; c < 4; c++)
    begin
      host.put(7'h44, 8'h00, {4'h8, 2'(c), 2'b00});
      if (c >= 1)
      begin
        k = 16 - 4 * c;
        // first period after the write may be partial; measure the next
        wait_done((8 << k) + 64);
        exp = 16'(rises);
        wait_done((8 << k) + 64);
        check(16'(rises) - exp, 16'(1 << k));
        check({dh, dl}, conv);
      end
    end
    host.put(7'h44, 8'h00, 8'h94);
    @(posedge osc);
    @(negedge clk_in);
    sync_w();
    // last interval is a whole multiple of a 12-cycle ripple period
    for (int i = 0; i < 4; i++)
    begin
      k = (i == 3) ? 12 * (1 + $urandom % 20) : 1 + $urandom % 300;
      repeat (k) @(posedge osc);
      @(negedge clk_in);
      sync_w();
      check({dh, dl}, 16'(k));
      check({15'h0000, ovf}, 16'h0000);
    end
    host.put(7'h44, 8'h00, 8'h90);
    repeat (20) @(negedge clk_in);
    conv = 16'($urandom);
    sync_w();
    check({dh, dl}, conv);
    host.put(7'h44, 8'h00, 8'h98);
    conv = ~conv;
    sync_w();
    sync_w();
    check({dh, dl}, ~conv);
    check({15'h0000, integ}, 16'h0000);
    host.put(7'h45, 8'h00, 8'h00);
    host.put(7'h44, 8'h01, 8'h00);
    @(negedge clk_in);
    check({8'h00, cmd}, 16'h0098);
    conclude();
  end
endmodule // tb
bind integration_timing timing_checker chk (.*);

// ==== verification/timing_assertions.sv ====
// port assertions for the integration timing block
// assumes a bind from tb by port name
module timing_checker (
  input wire clk_in,
  input wire reset_in,
  input wire write_strobe_in,
  input wire [6:0] target_addr_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] write_data_in,
  input wire [15:0] converter_count_in,
  input wire [7:0] command_out,
  input wire integrating_out,
  input wire conversion_done_out,
  input wire count_clear_out,
  input wire [7:0] data_low_out,
  input wire [7:0] data_high_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  wire hit = write_strobe_in && target_addr_in == 7'h44;
  wire sync = hit && reg_addr_in[7];
  wire ext = command_out[4:3] == 2'b10;
  wire [15:0] data = {data_high_out, data_low_out};
  property p_cmd; hit && reg_addr_in == 8'h00 |=> command_out == $past(write_data_in); endproperty
  a_cmd: assert property (p_cmd) else $error("command not taken");
  property p_tgt; write_strobe_in && target_addr_in != 7'h44 |=> $stable(command_out); endproperty
  a_tgt: assert property (p_tgt) else $error("foreign write taken");
  property p_clr; sync && ext |-> count_clear_out; endproperty
  a_clr: assert property (p_clr) else $error("sync gave no restart");
  // a sync in the cycle after leaving internal timing only starts a period
  property p_end; sync && ext && $past(ext) && integrating_out |-> conversion_done_out;
  endproperty
  a_end: assert property (p_end) else $error("sync did not end period");
  property p_run; sync && ext |=> integrating_out; endproperty
  a_run: assert property (p_run) else $error("sync did not start period");
  property p_rsv; command_out[4:3] == 2'b11 && $past(command_out[4:3]) == 2'b11
    |-> !conversion_done_out && $stable(data); endproperty
  a_rsv: assert property (p_rsv) else $error("reserved mode active");
  property p_upd; !$stable(data) |-> $past(conversion_done_out); endproperty
  a_upd: assert property (p_upd) else $error("data moved off period end");
  property p_pair; conversion_done_out |-> count_clear_out; endproperty
  a_pair: assert property (p_pair) else $error("end without restart");
  property p_adc; command_out[4:2] == 3'b100 && conversion_done_out
    |=> data == $past(converter_count_in); endproperty
  a_adc: assert property (p_adc) else $error("converter value lost");
endmodule // timing_checker
